// [logic/sseh_regs.svh]
// register offsets, field positions, codes and constants of the status and erase handler
`ifndef SSEH_REGS_SVH
`define SSEH_REGS_SVH
`define SSEH_OFF_CMD0     12'h000
`define SSEH_OFF_CMD1     12'h004
`define SSEH_OFF_CTRL     12'h008
`define SSEH_OFF_STAT     12'h00c
`define SSEH_OFF_RESULT   12'h010
`define SSEH_OFF_SENSE    12'h014
`define SSEH_OFF_EVENT    12'h018
`define SSEH_ST_GOOD      8'h00
`define SSEH_ST_CHECK     8'h02
`define SSEH_ST_BUSY      8'h08
`define SSEH_ST_CONFLICT  8'h18
`define SSEH_OP_REQSENSE  8'h03
`define SSEH_OP_INQUIRY   8'h12
`define SSEH_OP_ERASE     8'h19
`define SSEH_OP_WRITE     8'h0a
`define SSEH_OP_WRFM      8'h10
`define SSEH_OP_RESERVE   8'h16
`define SSEH_OP_RELEASE   8'h17
`define SSEH_OP_TUR       8'h00
`define SSEH_KEY_NONE     4'h0
`define SSEH_KEY_ILLEGAL  4'h5
`define SSEH_KEY_UATTN    4'h6
`define SSEH_KEY_MEDIUM   4'h3
`define SSEH_ASC_OPCODE   8'h20
`define SSEH_ASC_FIELD    8'h24
`define SSEH_ASC_LUN      8'h25
`define SSEH_ASC_PARITY   8'h47
`define SSEH_ASC_UATTN    8'h29
`define SSEH_ASC_WRERR    8'h0c
`define SSEH_BIT_EARLY    1
`define SSEH_BIT_ERASEEN  0
`define SSEH_CTRL_GO      0
`define SSEH_CTRL_PARERR  1
`define SSEH_CTRL_BUSY    2
`define SSEH_CTRL_DISC    3
`define SSEH_CTRL_PART2   4
`define SSEH_EV_BUSRST    0
`define SSEH_EV_DEVRST    1
`define SSEH_EV_CARTCHG   2
`define SSEH_EV_FLUSHOK   3
`define SSEH_EV_FLUSHERR  4
`define SSEH_EV_ERASEDONE 5
`define SSEH_EV_ERASEERR  6
`define SSEH_EV_REWDONE   7
`define SSEH_EV_RECONN    8
`endif

// [logic/sseh_pkg.sv]
// types of the status and erase handler
package sseh_pkg;
	typedef enum {SSEH_IDLE, SSEH_FLUSH, SSEH_ERASE, SSEH_REWIND, SSEH_RECONN} sseh_state_t;
	typedef struct packed {
		logic [3:0] key;
		logic [7:0] asc;
		logic [7:0] ascq;
	} sseh_sense_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] control;
		logic [7:0] rsvdOr;
		logic [2:0] initiator;
	} sseh_cmd_t;
endpackage : sseh_pkg

// [logic/sseh_status_erase.sv]
// status byte generation and erase sequencing behind an APB register file
`timescale 1ns/1ps
`include "sseh_regs.svh"
module sseh_status_erase
	import sseh_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// tape mechanism
	output logic             flushReq,
	output logic             eraseReq,
	output logic             rewindReq,
	output logic             rewindPartition,
	output logic             disconnected,
	// status byte toward the bus phase logic
	output logic [7:0]       statusByte,
	output logic             statusValid
);

	sseh_state_t  state_q;
	sseh_cmd_t    cmd_q;
	sseh_sense_t  sense_q;
	logic [7:0]   uattn_q;
	logic [7:0]   deferred_q;
	logic         resvd_q;
	logic [2:0]   owner_q;
	logic         pendWrite_q;
	logic         lastWasWrite_q;
	logic         early_q;
	logic         eraseEn_q;
	logic         busy_q;
	logic         discEn_q;
	logic         part2_q;
	logic [7:0]   pendStatus_q;
	logic [8:0]   evt;
	logic         go;
	logic         wrAcc;

	// status byte code sits in bits 5..1; bits 7, 6 and 0 forced to zero
	function automatic logic [7:0] fmtStatus(input logic [7:0] s);
		fmtStatus = {2'b00, s[5:1], 1'b0};
	endfunction : fmtStatus

	function automatic logic supported(input logic [7:0] op);
		case (op)
			`SSEH_OP_TUR, `SSEH_OP_REQSENSE, `SSEH_OP_INQUIRY, `SSEH_OP_ERASE, `SSEH_OP_WRITE,
			`SSEH_OP_WRFM, `SSEH_OP_RESERVE, `SSEH_OP_RELEASE: supported = 1'b1;
			default: supported = 1'b0;
		endcase
	endfunction : supported

	function automatic logic isWriteOp(input logic [7:0] op);
		isWriteOp = op == `SSEH_OP_WRITE || op == `SSEH_OP_WRFM;
	endfunction : isWriteOp

	// reserved, flag, link and vendor bits that must read zero
	function automatic logic fieldBad(input sseh_cmd_t c);
		fieldBad = c.control[5:0] != 6'h00 || c.rsvdOr != 8'h00;
		if (c.opcode == `SSEH_OP_ERASE) begin
			fieldBad = fieldBad || c.byte1[4:2] != 3'b000 || c.control[7:6] != 2'b00;
		end
		if (c.opcode == `SSEH_OP_INQUIRY) begin
			fieldBad = fieldBad || c.control[7:6] != 2'b00;
		end
	endfunction : fieldBad

	// write access phase hitting one register
	function automatic logic regWr(input logic [11:0] a);
		regWr = wrAcc && paddr == a;
	endfunction : regWr

	assign wrAcc = psel && penable && pwrite;
	assign go    = regWr(`SSEH_OFF_CTRL) && pwdata[`SSEH_CTRL_GO];
	assign evt   = regWr(`SSEH_OFF_EVENT) ? pwdata[8:0] : 9'h000;

	// apb slave: zero wait states, unmapped reads zero with error
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					`SSEH_OFF_CMD0:   prdata <= {8'h00, cmd_q.control, cmd_q.byte1, cmd_q.opcode};
					`SSEH_OFF_CMD1:   prdata <= {21'h0, cmd_q.initiator, cmd_q.rsvdOr};
					`SSEH_OFF_CTRL:   prdata <= {27'h0, part2_q, discEn_q, busy_q, 2'b00};
					`SSEH_OFF_STAT:   prdata <= {8'h00, uattn_q, deferred_q, resvd_q, owner_q, 1'b0, state_q == SSEH_IDLE,
						disconnected, pendWrite_q};
					`SSEH_OFF_RESULT: prdata <= {24'h0, statusByte};
					`SSEH_OFF_SENSE:  prdata <= {12'h0, sense_q};
					`SSEH_OFF_EVENT:  prdata <= 32'h0000_0000;
					default:          pslverr <= 1'b1;
				endcase
			end
		end
	end

	// command descriptor capture
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_q <= '0;
		end else if (regWr(`SSEH_OFF_CMD0)) begin
			cmd_q.opcode  <= pwdata[7:0];
			cmd_q.byte1   <= pwdata[15:8];
			cmd_q.control <= pwdata[23:16];
		end else if (regWr(`SSEH_OFF_CMD1)) begin
			cmd_q.rsvdOr    <= pwdata[7:0];
			cmd_q.initiator <= pwdata[10:8];
		end
	end

	// software controls
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy_q   <= 1'b0;
			discEn_q <= 1'b0;
			part2_q  <= 1'b0;
		end else if (regWr(`SSEH_OFF_CTRL)) begin
			busy_q   <= pwdata[`SSEH_CTRL_BUSY];
			discEn_q <= pwdata[`SSEH_CTRL_DISC];
			part2_q  <= pwdata[`SSEH_CTRL_PART2];
		end
	end

	logic [7:0] iniBit;
	logic       anyReset;
	logic       flushNeed;
	assign iniBit    = 8'h01 << cmd_q.initiator;
	assign anyReset  = evt[`SSEH_EV_BUSRST] || evt[`SSEH_EV_DEVRST];
	// buffered writes from the previous command still to reach tape
	assign flushNeed = pendWrite_q && lastWasWrite_q;

	// command decode, status choice and erase sequencing
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q        <= SSEH_IDLE;
			sense_q        <= '0;
			statusByte     <= `SSEH_ST_GOOD;
			statusValid    <= 1'b0;
			uattn_q        <= 8'hff;
			deferred_q     <= 8'h00;
			resvd_q        <= 1'b0;
			owner_q        <= 3'd0;
			pendWrite_q    <= 1'b0;
			lastWasWrite_q <= 1'b0;
			early_q        <= 1'b0;
			eraseEn_q      <= 1'b0;
			flushReq       <= 1'b0;
			eraseReq       <= 1'b0;
			rewindReq      <= 1'b0;
			rewindPartition <= 1'b0;
			disconnected   <= 1'b0;
			pendStatus_q   <= `SSEH_ST_GOOD;
		end else begin
			statusValid <= 1'b0;
			flushReq    <= 1'b0;
			eraseReq    <= 1'b0;
			rewindReq   <= 1'b0;
			if (anyReset) begin
				uattn_q <= 8'hff;
				resvd_q <= 1'b0;
			end else if (evt[`SSEH_EV_CARTCHG]) begin
				uattn_q <= 8'hff;
			end
			// commands met while an erase runs are turned away, not queued
			if (go && state_q != SSEH_IDLE && !disconnected) begin
				statusValid <= 1'b1;
				statusByte  <= fmtStatus(`SSEH_ST_BUSY);
			end
			case (state_q)
				SSEH_IDLE: begin
					if (go) begin
						statusValid <= 1'b1;
						if (pwdata[`SSEH_CTRL_BUSY]) begin
							statusByte <= fmtStatus(`SSEH_ST_BUSY);
						end else if (pwdata[`SSEH_CTRL_PARERR]) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							sense_q    <= '{`SSEH_KEY_ILLEGAL, `SSEH_ASC_PARITY, 8'h00};
						end else if (cmd_q.byte1[7:5] != 3'b000) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							sense_q    <= '{`SSEH_KEY_ILLEGAL, `SSEH_ASC_LUN, 8'h00};
						end else if (!supported(cmd_q.opcode)) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							sense_q    <= '{`SSEH_KEY_ILLEGAL, `SSEH_ASC_OPCODE, 8'h00};
						end else if (fieldBad(cmd_q)) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							sense_q    <= '{`SSEH_KEY_ILLEGAL, `SSEH_ASC_FIELD, 8'h00};
						end else if (resvd_q && owner_q != cmd_q.initiator && cmd_q.opcode != `SSEH_OP_REQSENSE
							&& cmd_q.opcode != `SSEH_OP_INQUIRY) begin
							statusByte <= fmtStatus(`SSEH_ST_CONFLICT);
						end else if ((uattn_q & iniBit) != 8'h00 && cmd_q.opcode != `SSEH_OP_INQUIRY) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							sense_q    <= '{`SSEH_KEY_UATTN, `SSEH_ASC_UATTN, 8'h00};
							uattn_q    <= uattn_q & ~iniBit;
						end else if ((deferred_q & iniBit) != 8'h00) begin
							statusByte <= fmtStatus(`SSEH_ST_CHECK);
							deferred_q <= deferred_q & ~iniBit;
						end else begin
							statusByte     <= fmtStatus(`SSEH_ST_GOOD);
							lastWasWrite_q <= isWriteOp(cmd_q.opcode);
							if (isWriteOp(cmd_q.opcode)) begin
								pendWrite_q <= 1'b1;
							end
							if (cmd_q.opcode == `SSEH_OP_RESERVE) begin
								resvd_q <= 1'b1;
								owner_q <= cmd_q.initiator;
							end
							if (cmd_q.opcode == `SSEH_OP_RELEASE && owner_q == cmd_q.initiator) begin
								resvd_q <= 1'b0;
							end
							if (cmd_q.opcode == `SSEH_OP_ERASE) begin
								early_q      <= cmd_q.byte1[`SSEH_BIT_EARLY];
								eraseEn_q    <= cmd_q.byte1[`SSEH_BIT_ERASEEN];
								// early status with nothing buffered ends the command here, so no disconnect
								disconnected <= pwdata[`SSEH_CTRL_DISC]
									&& (flushNeed || !cmd_q.byte1[`SSEH_BIT_EARLY]);
								owner_q      <= resvd_q ? owner_q : cmd_q.initiator;
								rewindPartition <= pwdata[`SSEH_CTRL_PART2];
								statusValid  <= cmd_q.byte1[`SSEH_BIT_EARLY] && !flushNeed;
								if (flushNeed) begin
									flushReq <= 1'b1;
									state_q  <= SSEH_FLUSH;
								end else if (cmd_q.byte1[`SSEH_BIT_ERASEEN]) begin
									eraseReq <= 1'b1;
									state_q  <= SSEH_ERASE;
								end else if (!cmd_q.byte1[`SSEH_BIT_EARLY]) begin
									statusValid  <= 1'b1;
									disconnected <= 1'b0;
								end
							end
						end
					end
				end
				SSEH_FLUSH: begin
					if (evt[`SSEH_EV_FLUSHERR]) begin
						pendWrite_q    <= 1'b0;
						statusByte     <= fmtStatus(`SSEH_ST_CHECK);
						sense_q        <= '{`SSEH_KEY_MEDIUM, `SSEH_ASC_WRERR, 8'h00};
						pendStatus_q   <= fmtStatus(`SSEH_ST_CHECK);
						state_q        <= disconnected ? SSEH_RECONN : SSEH_IDLE;
						statusValid    <= !disconnected;
					end else if (evt[`SSEH_EV_FLUSHOK]) begin
						pendWrite_q <= 1'b0;
						if (early_q) begin
							disconnected <= 1'b0;
							statusByte   <= fmtStatus(`SSEH_ST_GOOD);
							statusValid  <= 1'b1;
						end
						if (eraseEn_q) begin
							eraseReq <= 1'b1;
							state_q  <= SSEH_ERASE;
						end else if (!early_q) begin
							pendStatus_q <= fmtStatus(`SSEH_ST_GOOD);
							state_q      <= disconnected ? SSEH_RECONN : SSEH_IDLE;
							statusByte   <= fmtStatus(`SSEH_ST_GOOD);
							statusValid  <= !disconnected;
						end else begin
							state_q <= SSEH_IDLE;
						end
					end
				end
				SSEH_ERASE: begin
					if (evt[`SSEH_EV_ERASEERR]) begin
						sense_q <= '{`SSEH_KEY_MEDIUM, 8'h00, 8'h00};
						if (early_q) begin
							deferred_q <= deferred_q | (8'h01 << owner_q);
							state_q    <= SSEH_IDLE;
						end else begin
							pendStatus_q <= fmtStatus(`SSEH_ST_CHECK);
							statusByte   <= fmtStatus(`SSEH_ST_CHECK);
							statusValid  <= !disconnected;
							state_q      <= disconnected ? SSEH_RECONN : SSEH_IDLE;
						end
					end else if (evt[`SSEH_EV_ERASEDONE]) begin
						rewindReq <= 1'b1;
						state_q   <= SSEH_REWIND;
					end
				end
				SSEH_REWIND: begin
					if (evt[`SSEH_EV_REWDONE]) begin
						if (early_q) begin
							state_q <= SSEH_IDLE;
						end else begin
							pendStatus_q <= fmtStatus(`SSEH_ST_GOOD);
							statusByte   <= fmtStatus(`SSEH_ST_GOOD);
							statusValid  <= !disconnected;
							state_q      <= disconnected ? SSEH_RECONN : SSEH_IDLE;
						end
					end
				end
				SSEH_RECONN: begin
					if (evt[`SSEH_EV_RECONN]) begin
						disconnected <= 1'b0;
						statusByte   <= pendStatus_q;
						statusValid  <= 1'b1;
						state_q      <= SSEH_IDLE;
					end
				end
				default: state_q <= SSEH_IDLE;
			endcase
		end
	end

endmodule : sseh_status_erase

// [bench/sseh_initiator_model.sv]
// initiator-side model: takes each status byte and counts tape requests
`timescale 1ns/1ps
module sseh_initiator_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// from the device
	input  wire logic [7:0] statusByte,
	input  wire logic       statusValid,
	input  wire logic       flushReq,
	input  wire logic       eraseReq,
	input  wire logic       rewindReq,
	// observations
	output int              nStat,
	output int              nFlush,
	output int              nErase,
	output int              nRew,
	output logic [7:0]      lastStat
);
	// one status byte taken per pulse
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nStat    <= 0;
			lastStat <= 8'h00;
		end else if (statusValid) begin
			nStat    <= nStat + 1;
			lastStat <= statusByte;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nFlush <= 0;
			nErase <= 0;
			nRew   <= 0;
		end else begin
			nFlush <= nFlush + int'(flushReq);
			nErase <= nErase + int'(eraseReq);
			nRew   <= nRew + int'(rewindReq);
		end
	end
endmodule : sseh_initiator_model

// [bench/sseh_status_erase_properties.sv]
// port assertions of the status and erase handler
`timescale 1ns/1ps
`include "sseh_regs.svh"
module sseh_status_erase_properties
	import sseh_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// tape and status
	input wire logic        flushReq,
	input wire logic        eraseReq,
	input wire logic        rewindReq,
	input wire logic        rewindPartition,
	input wire logic        disconnected,
	input wire logic [7:0]  statusByte,
	input wire logic        statusValid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire logic goWr = psel && penable && pready && pwrite && paddr == `SSEH_OFF_CTRL && pwdata[`SSEH_CTRL_GO];
	status_reserved_zero_bit_a: assert property (statusValid |-> statusByte[7:6] == 2'h0 && statusByte[0] == 1'b0)
		else $error("status reserved bits set");
	status_code_a: assert property (statusValid |-> statusByte inside {8'h00, 8'h02, 8'h08, 8'h18})
		else $error("status code not defined");
	single_status_a: assert property (statusValid |=> !statusValid)
		else $error("status sent twice");
	busy_answer_a: assert property (goWr && pwdata[`SSEH_CTRL_BUSY] |=> !statusValid || statusByte == `SSEH_ST_BUSY)
		else $error("busy command not answered busy");
	parity_check_a: assert property (goWr && pwdata[`SSEH_CTRL_PARERR] && !pwdata[`SSEH_CTRL_BUSY]
		|=> !statusValid || statusByte == `SSEH_ST_CHECK)
		else $error("bad descriptor not answered check");
	flush_first_a: assert property (flushReq |-> !eraseReq ##1 !eraseReq)
		else $error("erase started with flush");
	disc_silent_a: assert property (disconnected |-> !statusValid)
		else $error("status while disconnected");
	rewind_pulse_a: assert property (rewindReq |=> !rewindReq)
		else $error("rewind request held");
	cover property (statusValid && statusByte == `SSEH_ST_CONFLICT);
	cover property (rewindReq && rewindPartition);
	cover property (disconnected ##1 !disconnected);
endmodule : sseh_status_erase_properties
bind sseh_status_erase sseh_status_erase_properties chk_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .flushReq, .eraseReq, .rewindReq, .rewindPartition, .disconnected, .statusByte, .statusValid);

// [bench/tb_top.sv]
// self-checking bench of the status and erase handler
`timescale 1ns/1ps
`include "sseh_regs.svh"
module tb_top;
	import sseh_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, flushReq, eraseReq, rewindReq, rewindPartition, disconnected, statusValid, err;
	logic [7:0] statusByte, lastStat;
	int fails = 0, cmp_count = 0, expN = 0, nStat, nFlush, nErase, nRew;
	logic [39:0] errTab [5] = '{40'h5500000020, 40'h0020000025, 40'h0000010024, 40'h0000000124, 40'h1900400024};
	sseh_status_erase DUT (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.flushReq, .eraseReq, .rewindReq, .rewindPartition, .disconnected, .statusByte, .statusValid);
	sseh_initiator_model partner (.clk_sys, .rstn, .statusByte, .statusValid, .flushReq, .eraseReq, .rewindReq,
		.nStat, .nFlush, .nErase, .nRew, .lastStat);
	always #12.5 clk_sys = ~clk_sys;
	task finish_test;
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task cmd(input logic [2:0] ini, input logic [7:0] op, b1, cb, rs, input logic [4:0] ctl);
		apb(1'b1, `SSEH_OFF_CMD0, {8'h00, cb, b1, op});
		apb(1'b1, `SSEH_OFF_CMD1, {21'h0, ini, rs});
		apb(1'b1, `SSEH_OFF_CTRL, {27'h0, ctl} | 32'h1);
		repeat (2) @(posedge clk_sys);
	endtask : cmd
	task ev(input int b);
		apb(1'b1, `SSEH_OFF_EVENT, 32'h1 << b);
		repeat (2) @(posedge clk_sys);
	endtask : ev
	task sts(input logic [7:0] s);
		expN++;
		chk(nStat, expN);
		chk(lastStat, s);
	endtask : sts
	task sense(input logic [3:0] k, input logic [7:0] asc);
		apb(1'b0, `SSEH_OFF_SENSE, 32'h0);
		chk(rd, {12'h0, k, asc, 8'h00});
	endtask : sense
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_CHECK);
		sense(`SSEH_KEY_UATTN, `SSEH_ASC_UATTN);
		cmd(3'h1, `SSEH_OP_INQUIRY, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h1, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_CHECK);
		cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		for (int i = 0; i < 5; i++) begin
			cmd(3'h0, errTab[i][39:32], errTab[i][31:24], errTab[i][23:16], errTab[i][15:8], 5'h0);
			sts(`SSEH_ST_CHECK);
			sense(`SSEH_KEY_ILLEGAL, errTab[i][7:0]);
		end
		cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h02);
		sts(`SSEH_ST_CHECK);
		repeat (2) begin
			cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h04);
			sts(`SSEH_ST_BUSY);
		end
		cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_RESERVE, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h1, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_CONFLICT);
		cmd(3'h1, `SSEH_OP_REQSENSE, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h1, `SSEH_OP_INQUIRY, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_RELEASE, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h1, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_ERASE, 8'h01, 8'h0, 8'h0, 5'h0);
		chk(nStat, expN);
		chk(nErase, 1);
		ev(`SSEH_EV_ERASEDONE);
		chk(nRew, 1);
		chk(rewindPartition, 1'b0);
		chk(nStat, expN);
		ev(`SSEH_EV_REWDONE);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_ERASE, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		chk(nErase, 1);
		cmd(3'h0, `SSEH_OP_WRITE, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_ERASE, 8'h03, 8'h0, 8'h0, 5'h10);
		chk(nFlush, 1);
		chk(nErase, 1);
		ev(`SSEH_EV_FLUSHOK);
		sts(`SSEH_ST_GOOD);
		chk(nErase, 2);
		ev(`SSEH_EV_ERASEDONE);
		chk(rewindPartition, 1'b1);
		chk(nRew, 2);
		ev(`SSEH_EV_REWDONE);
		chk(nStat, expN);
		cmd(3'h0, `SSEH_OP_WRFM, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h0, `SSEH_OP_ERASE, 8'h01, 8'h0, 8'h0, 5'h08);
		chk(nFlush, 2);
		chk(disconnected, 1'b1);
		ev(`SSEH_EV_FLUSHERR);
		chk(nStat, expN);
		ev(`SSEH_EV_RECONN);
		sts(`SSEH_ST_CHECK);
		chk(nErase, 2);
		sense(`SSEH_KEY_MEDIUM, `SSEH_ASC_WRERR);
		cmd(3'h0, `SSEH_OP_ERASE, 8'h03, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_GOOD);
		cmd(3'h1, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_BUSY);
		ev(`SSEH_EV_ERASEERR);
		cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
		sts(`SSEH_ST_CHECK);
		for (int b = 0; b < 3; b++) begin
			ev(b);
			cmd(3'h0, `SSEH_OP_TUR, 8'h0, 8'h0, 8'h0, 5'h0);
			sts(`SSEH_ST_CHECK);
		end
		apb(1'b0, 12'h01c, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule : tb_top
